// File: inc/spl_pkg.sv
// Shared constants and types of the switch port link control block.
// Assumes one 25 MHz clock and three x8 ports; port 0 faces upstream.
package spl_pkg;
  // Topology
  localparam int NPORT = 3;
  localparam int NLANE = 8;
  localparam int GRP_LANES = 4;
  localparam int UP_PORT = 0;
  // Timing: entry timer fields count in units of one microsecond
  localparam int CLK_NS = 40;
  localparam int TMR_UNIT_NS = 1000;
  localparam int TICK_CYC = (TMR_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 8;
  // Training symbol window checked for inverted polarity
  localparam logic [4:0] SYM_FIRST = 5'h06;
  localparam logic [4:0] SYM_LAST = 5'h10;
  // Full width encoding
  localparam logic [5:0] W_X8 = 6'h08;
  // Register offsets inside a port window, and global registers
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CAP = 5'h04;
  localparam logic [4:0] OFF_STS = 5'h08;
  localparam logic [4:0] OFF_DCAP = 5'h0c;
  localparam logic [4:0] OFF_SCAP = 5'h10;
  localparam logic [7:0] OFF_SWITCH_CONTROL_REG = 8'h60;
  localparam logic [7:0] OFF_PMCTL = 8'h64;
  // Field positions
  localparam int CTRL_RETRAIN = 0;
  localparam int CTRL_L0S_EN = 1;
  localparam int CTRL_L1_EN = 2;
  localparam int CTRL_DIS = 3;
  localparam int STS_LINKUP = 8;
  localparam int STS_INV_LSB = 16;
  localparam int DCAP_VAL_LSB = 8;
  localparam int PMCTL_L1_LSB = 8;
  localparam int SWITCH_CONTROL_REG_UNLOCK = 0;
  // Reset values
  localparam logic [7:0] RST_L0S_TMR = 8'h07;
  localparam logic [7:0] RST_L1_TMR = 8'h1f;
  // Upstream sleep request states
  typedef enum {L1_IDLE, L1_WAIT} spl_l1_st_t;
  // Status seen from one port's training and link logic
  typedef struct packed {
    logic train_start;
    logic train;
    logic [4:0] sym_idx;
    logic [NLANE-1:0] sym_inv;
    logic train_done;
    logic [5:0] neg_width;
    logic reversed;
    logic link_up;
    logic rx_l0s;
    logic in_l1;
    logic d3;
    logic tlp_idle;
    logic dllp_pend;
    logic spl_valid;
    logic [15:0] spl_payload;
    logic l1_ack;
    logic l1_nak;
  } spl_phy_in_t;
  // Commands to one port's training, lane and queue logic
  typedef struct packed {
    logic [NLANE-1:0] rx_invert;
    logic [NLANE-1:0] lane_off;
    logic [NLANE-1:0] lane_lp;
    logic [NLANE-1:0][2:0] lane_map;
    logic [5:0] max_width;
    logic retrain;
    logic flush;
    logic dest_ur;
    logic fc_adv;
    logic [7:0] fc_credits;
    logic spl_send;
    logic [31:0] spl_value;
    logic l0s_enter;
    logic l1_req;
    logic l1_enter;
  } spl_phy_out_t;
  // Register address decode result
  typedef struct packed {
    logic hit;
    logic glob;
    logic [1:0] port;
    logic [4:0] off;
  } spl_dec_t;
endpackage : spl_pkg

// File: hdl/spl_lane_ctrl.sv
// Per-port lane logic: polarity, lane power and reversal map.
// Assumes training status arrives on the same clock.
`timescale 1ns/1ps
module spl_lane_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Training observation
  input wire logic i_train_start,
  input wire logic i_train,
  input wire logic [4:0] i_sym_idx,
  input wire logic [spl_pkg::NLANE-1:0] i_sym_inv,
  // Width controls
  input wire logic [5:0] i_width,
  input wire logic [5:0] i_max_width,
  input wire logic i_reversed,
  input wire logic i_disabled,
  // Lane controls
  output logic [spl_pkg::NLANE-1:0] o_rx_invert,
  output logic [spl_pkg::NLANE-1:0] o_lane_off,
  output logic [spl_pkg::NLANE-1:0] o_lane_lp,
  output logic [spl_pkg::NLANE-1:0][2:0] o_lane_map
);
  import spl_pkg::*;
  // High while a checked training symbol is on the lanes
  logic in_win;
  assign in_win = i_train && (i_sym_idx >= SYM_FIRST) && (i_sym_idx <= SYM_LAST);
  for (genvar l = 0; l < NLANE; l++)
  begin : g_lane
    localparam logic [5:0] LIDX = 6'(l);
    // Each lane decides alone; transmit data is never touched
    always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
        o_rx_invert[l] <= 1'b0;
      else if (i_train_start)
        o_rx_invert[l] <= 1'b0;
      else if (in_win && i_sym_inv[l])
        o_rx_invert[l] <= 1'b1;
    // Lanes of an enabled port stay powered while training so any width can be reached
    always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
      begin
        o_lane_off[l] <= 1'b0;
        o_lane_lp[l] <= 1'b0;
      end
      else
      begin
        o_lane_off[l] <= i_disabled || (!i_train && (i_width < W_X8) && (l >= GRP_LANES));
        o_lane_lp[l] <= !i_disabled && !i_train && (l < GRP_LANES) && (LIDX >= i_width);
      end
    // Reversed lanes mirror inside the configured maximum width
    always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
        o_lane_map[l] <= 3'(l);
      else if (i_reversed && (LIDX < i_max_width))
        o_lane_map[l] <= 3'(i_max_width - 6'h01 - LIDX);
      else
        o_lane_map[l] <= 3'(l);
  end
  a_pol_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    in_win && !i_train_start && i_sym_inv[0] |=> o_rx_invert[0]) else $error("lane polarity not corrected");
  a_grp_off: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !i_train && (i_width < W_X8) |=> &o_lane_off[NLANE-1:GRP_LANES]) else $error("upper lane group powered");
  a_port_off: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_disabled |=> &o_lane_off) else $error("disabled port lane powered");
endmodule : spl_lane_ctrl

// File: hdl/spl_pm_timer.sv
// Entry timer: one pulse once a condition held for the set time.
// Assumes the condition is a same-clock level.
`timescale 1ns/1ps
module spl_pm_timer #(
  parameter int TICKS = spl_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Condition and hold time in units
  input wire logic i_cond,
  input wire logic [spl_pkg::TMR_W-1:0] i_limit,
  // Entry pulse
  output logic o_fire
);
  import spl_pkg::*;
  localparam int PW = $clog2(TICKS + 1);
  logic [PW-1:0] pre_r; // Cycles inside one unit
  logic [TMR_W-1:0] unit_r; // Whole units held
  logic done_r; // Fired for this stretch
  logic tick;
  assign tick = i_cond && (pre_r == PW'(TICKS - 1));
  // Any gap in the condition restarts the whole count
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      pre_r <= '0;
    else if (!i_cond || tick)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  // Unit count saturates at the limit
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      unit_r <= '0;
    else if (!i_cond)
      unit_r <= '0;
    else if (tick && (unit_r < i_limit))
      unit_r <= unit_r + 1'b1;
  // One pulse per stretch of the condition
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      o_fire <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      o_fire <= i_cond && !done_r && !o_fire && (unit_r >= i_limit);
      done_r <= i_cond && (done_r || o_fire);
    end
  a_fire_held: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    o_fire |-> $past(i_cond) && ($past(unit_r) >= $past(i_limit))) else $error("entry before timer expired");
endmodule : spl_pm_timer

// File: hdl/spl_link_ctrl.sv
// Link control of a three-port x8 switch, with an APB register slave.
// Assumes training, queue and power logic on the same clock; port 0 upstream.
`timescale 1ns/1ps
module spl_link_ctrl #(
  // Credits advertised from each input buffer queue
  parameter logic [7:0] IFB_CREDITS = 8'h20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Per-port link side
  input wire spl_pkg::spl_phy_in_t [spl_pkg::NPORT-1:0] i_phy,
  output spl_pkg::spl_phy_out_t [spl_pkg::NPORT-1:0] o_phy
);
  import spl_pkg::*;

  // Decoding shared by the read mux and the write path
  function automatic spl_dec_t spl_decode(input logic [7:0] a);
    spl_dec_t d;
    d.port = a[6:5];
    d.off = a[4:0];
    d.glob = (a == OFF_SWITCH_CONTROL_REG) || (a == OFF_PMCTL);
    d.hit = d.glob || (!a[7] && (int'(a[6:5]) < NPORT) && (a[4:0] <= OFF_SCAP) && (a[1:0] == 2'h0));
    return d;
  endfunction : spl_decode

  // Software state
  logic unlock_r; // Global register unlock
  logic [TMR_W-1:0] l0s_tmr_r; // Standby entry timer
  logic [TMR_W-1:0] l1_tmr_r; // Sleep entry timer
  logic [NPORT-1:0] l0s_en_r; // ASPM standby enable
  logic [NPORT-1:0] l1_en_r; // ASPM sleep enable
  logic [NPORT-1:0] dis_r; // Port disable
  logic [NPORT-1:0][5:0] maxw_r; // Max width cap
  logic [NPORT-1:0][31:0] scap_r; // Slot capabilities
  logic [NPORT-1:0][5:0] nw_r; // Negotiated width
  logic [7:0] cscale_r; // Captured power scale
  logic [1:0] cvalue_r; // Captured power value
  // Flopped outputs
  logic [NPORT-1:0][5:0] trainmax_r;
  logic [NPORT-1:0] retrain_r;
  logic [NPORT-1:0] flush_r;
  logic [NPORT-1:0] ur_r;
  logic [NPORT-1:0] fcadv_r;
  logic [NPORT-1:0] spl_r;
  logic [NPORT-1:0] l0s_r;
  logic [NPORT-1:0] lu_q; // Link up one cycle ago
  logic l1req_r;
  logic l1ent_r;
  spl_l1_st_t l1_st_r;
  // Lane module outputs
  logic [NPORT-1:0][NLANE-1:0] inv_w;
  logic [NPORT-1:0][NLANE-1:0] off_w;
  logic [NPORT-1:0][NLANE-1:0] lp_w;
  logic [NPORT-1:0][NLANE-1:0][2:0] map_w;
  // Bus decode
  spl_dec_t dec;
  logic first_acc; // First access cycle, answer next
  logic wr_commit; // Write takes effect at this edge
  logic [31:0] rdat;
  // Power management terms
  logic [NPORT-1:0] l0s_cond;
  logic [NPORT-1:0] l0s_fire;
  logic l1_cond;
  logic l1_fire;
  logic dn_l0s_ok;
  logic dn_l1_ok;

  assign dec = spl_decode(i_paddr);
  assign first_acc = i_psel && i_penable && !o_pready;
  assign wr_commit = i_psel && i_penable && o_pready && i_pwrite && dec.hit;

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end
    else
    begin
      o_pready <= first_acc;
      o_pslverr <= first_acc && !dec.hit;
      o_prdata <= first_acc && !i_pwrite ? rdat : '0;
    end

  // Read mux; a down link never blocks these reads
  always_comb
  begin
    rdat = '0;
    if (dec.glob)
    begin
      if (i_paddr == OFF_SWITCH_CONTROL_REG)
        rdat[SWITCH_CONTROL_REG_UNLOCK] = unlock_r;
      else
      begin
        rdat[TMR_W-1:0] = l0s_tmr_r;
        rdat[PMCTL_L1_LSB +: TMR_W] = l1_tmr_r;
      end
    end
    else if (dec.hit)
      case (dec.off)
        OFF_CTRL:
        begin
          rdat[CTRL_L0S_EN] = l0s_en_r[dec.port];
          rdat[CTRL_L1_EN] = l1_en_r[dec.port];
          rdat[CTRL_DIS] = dis_r[dec.port];
        end
        OFF_CAP: rdat[5:0] = maxw_r[dec.port];
        OFF_STS:
        begin
          rdat[5:0] = nw_r[dec.port];
          rdat[STS_LINKUP] = i_phy[dec.port].link_up;
          rdat[STS_INV_LSB +: NLANE] = inv_w[dec.port];
        end
        OFF_DCAP:
        begin
          if (int'(dec.port) == UP_PORT)
          begin
            rdat[7:0] = cscale_r;
            rdat[DCAP_VAL_LSB +: 2] = cvalue_r;
          end
        end
        OFF_SCAP: rdat = scap_r[dec.port];
        default: rdat = '0;
      endcase
  end

  // Global registers
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      unlock_r <= 1'b0;
      l0s_tmr_r <= RST_L0S_TMR;
      l1_tmr_r <= RST_L1_TMR;
    end
    else if (wr_commit && dec.glob)
    begin
      if (i_paddr == OFF_SWITCH_CONTROL_REG)
        unlock_r <= i_pwdata[SWITCH_CONTROL_REG_UNLOCK];
      else
      begin
        l0s_tmr_r <= i_pwdata[TMR_W-1:0];
        l1_tmr_r <= i_pwdata[PMCTL_L1_LSB +: TMR_W];
      end
    end

  // Per-port control registers
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      l0s_en_r <= '0;
      l1_en_r <= '0;
      dis_r <= '0;
      maxw_r <= {NPORT{W_X8}};
      scap_r <= '0;
    end
    else if (wr_commit && !dec.glob)
      case (dec.off)
        OFF_CTRL:
        begin
          l0s_en_r[dec.port] <= i_pwdata[CTRL_L0S_EN];
          l1_en_r[dec.port] <= i_pwdata[CTRL_L1_EN];
          dis_r[dec.port] <= i_pwdata[CTRL_DIS];
        end
        OFF_CAP:
        begin
          // A locked write is dropped without an error answer
          if (unlock_r)
            maxw_r[dec.port] <= i_pwdata[5:0];
        end
        OFF_SCAP: scap_r[dec.port] <= i_pwdata;
        default: ;
      endcase

  // Retrain pulse sends the link state machine to Recovery
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      retrain_r <= '0;
    else
      for (int p = 0; p < NPORT; p++)
        retrain_r[p] <= wr_commit && !dec.glob && (int'(dec.port) == p) && (dec.off == OFF_CTRL)
          && i_pwdata[CTRL_RETRAIN] && ((p != UP_PORT) || unlock_r);

  // Cap is handed to training only when training starts
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      trainmax_r <= {NPORT{W_X8}};
    else
      for (int p = 0; p < NPORT; p++)
        if (i_phy[p].train_start)
          trainmax_r[p] <= maxw_r[p];

  // Negotiated width from the end of training
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      nw_r <= '0;
    else
      for (int p = 0; p < NPORT; p++)
        if (i_phy[p].train_done)
          nw_r[p] <= i_phy[p].neg_width;

  // Link up and down events
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      lu_q <= '0;
      flush_r <= '0;
      ur_r <= {NPORT{1'b1}};
      fcadv_r <= '0;
    end
    else
      for (int p = 0; p < NPORT; p++)
      begin
        lu_q[p] <= i_phy[p].link_up;
        flush_r[p] <= lu_q[p] && !i_phy[p].link_up;
        ur_r[p] <= !i_phy[p].link_up;
        fcadv_r[p] <= !lu_q[p] && i_phy[p].link_up;
      end

  // Slot power capture on the upstream port
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      cscale_r <= '0;
      cvalue_r <= '0;
    end
    else if (i_phy[UP_PORT].spl_valid)
    begin
      cscale_r <= i_phy[UP_PORT].spl_payload[7:0];
      cvalue_r <= i_phy[UP_PORT].spl_payload[DCAP_VAL_LSB +: 2];
    end

  // Slot power message on downstream ports
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      spl_r <= '0;
    else
      for (int p = 0; p < NPORT; p++)
        spl_r[p] <= (p != UP_PORT) && ((!lu_q[p] && i_phy[p].link_up) || (wr_commit && !dec.glob
          && (int'(dec.port) == p) && (dec.off == OFF_SCAP) && i_phy[p].link_up));

  // Entry conditions; D3 or down downstream ports are ignored
  always_comb
  begin
    dn_l0s_ok = 1'b1;
    dn_l1_ok = 1'b1;
    for (int q = 0; q < NPORT; q++)
      if ((q != UP_PORT) && !i_phy[q].d3 && i_phy[q].link_up)
      begin
        dn_l0s_ok = dn_l0s_ok && i_phy[q].rx_l0s;
        dn_l1_ok = dn_l1_ok && i_phy[q].in_l1;
      end
    for (int p = 0; p < NPORT; p++)
      l0s_cond[p] = l0s_en_r[p] && i_phy[p].link_up && !i_phy[p].in_l1 && i_phy[p].tlp_idle
        && !i_phy[p].dllp_pend && ((p == UP_PORT) ? dn_l0s_ok : i_phy[UP_PORT].rx_l0s);
    l1_cond = l1_en_r[UP_PORT] && i_phy[UP_PORT].link_up && !i_phy[UP_PORT].in_l1 && dn_l1_ok
      && i_phy[UP_PORT].tlp_idle && !i_phy[UP_PORT].dllp_pend && (l1_st_r == L1_IDLE);
  end

  // Standby timers and lane logic, one per port
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    spl_pm_timer #(.TICKS(TICK_CYC)) u_l0s_tmr (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_cond(l0s_cond[p]),
      .i_limit(l0s_tmr_r),
      .o_fire(l0s_fire[p])
    );
    spl_lane_ctrl u_lane (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_train_start(i_phy[p].train_start),
      .i_train(i_phy[p].train),
      .i_sym_idx(i_phy[p].sym_idx),
      .i_sym_inv(i_phy[p].sym_inv),
      .i_width(nw_r[p]),
      .i_max_width(trainmax_r[p]),
      .i_reversed(i_phy[p].reversed),
      .i_disabled(dis_r[p]),
      .o_rx_invert(inv_w[p]),
      .o_lane_off(off_w[p]),
      .o_lane_lp(lp_w[p]),
      .o_lane_map(map_w[p])
    );
  end

  // Sleep timer exists only upstream
  spl_pm_timer #(.TICKS(TICK_CYC)) u_l1_tmr (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cond(l1_cond),
    .i_limit(l1_tmr_r),
    .o_fire(l1_fire)
  );

  // Sleep request handshake with the upstream partner
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      l1_st_r <= L1_IDLE;
    else
      case (l1_st_r)
        L1_IDLE: if (l1_fire) l1_st_r <= L1_WAIT;
        L1_WAIT: if (i_phy[UP_PORT].l1_ack || i_phy[UP_PORT].l1_nak) l1_st_r <= L1_IDLE;
        default: l1_st_r <= L1_IDLE;
      endcase

  // Entry pulses; a refused sleep request falls back to standby
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      l1req_r <= 1'b0;
      l1ent_r <= 1'b0;
      l0s_r <= '0;
    end
    else
    begin
      l1req_r <= l1_fire;
      l1ent_r <= (l1_st_r == L1_WAIT) && i_phy[UP_PORT].l1_ack;
      for (int p = 0; p < NPORT; p++)
        l0s_r[p] <= l0s_fire[p] || ((p == UP_PORT) && (l1_st_r == L1_WAIT)
          && !i_phy[UP_PORT].l1_ack && i_phy[UP_PORT].l1_nak);
    end

  // Output bundles, every field but fc_credits and downstream l1_req/l1_enter (tied low) straight from a flop; fc_credits is the IFB_CREDITS parameter
  always_comb
    for (int p = 0; p < NPORT; p++)
    begin
      o_phy[p].rx_invert = inv_w[p];
      o_phy[p].lane_off = off_w[p];
      o_phy[p].lane_lp = lp_w[p];
      o_phy[p].lane_map = map_w[p];
      o_phy[p].max_width = trainmax_r[p];
      o_phy[p].retrain = retrain_r[p];
      o_phy[p].flush = flush_r[p];
      o_phy[p].dest_ur = ur_r[p];
      o_phy[p].fc_adv = fcadv_r[p];
      o_phy[p].fc_credits = IFB_CREDITS;
      o_phy[p].spl_send = spl_r[p];
      o_phy[p].spl_value = scap_r[p];
      o_phy[p].l0s_enter = l0s_r[p];
      o_phy[p].l1_req = (p == UP_PORT) && l1req_r;
      o_phy[p].l1_enter = (p == UP_PORT) && l1ent_r;
    end

  // Checks
  sequence s_up_retrain_locked;
    wr_commit && !dec.glob && (dec.port == 2'h0) && (dec.off == OFF_CTRL) && !unlock_r;
  endsequence
  sequence s_l1_grant;
    l1req_r ##1 i_phy[UP_PORT].l1_ack;
  endsequence
  a_retrain_lock: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    s_up_retrain_locked |=> !retrain_r[UP_PORT]) else $error("locked upstream retrain");
  a_retrain_dn: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    wr_commit && !dec.glob && (dec.port == 2'h1) && (dec.off == OFF_CTRL) && i_pwdata[CTRL_RETRAIN]
    |=> retrain_r[1]) else $error("downstream retrain lost");
  a_maxw_lock: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !unlock_r |=> $stable(maxw_r)) else $error("max width changed while locked");
  a_maxw_defer: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !i_phy[1].train_start |=> $stable(trainmax_r[1])) else $error("width cap applied outside training");
  a_flush_down: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    $fell(i_phy[2].link_up) |=> flush_r[2] ##1 !flush_r[2]) else $error("no flush on link down");
  a_spl_capture: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_phy[UP_PORT].spl_valid |=> cscale_r == $past(i_phy[UP_PORT].spl_payload[7:0])) else $error("power scale");
  a_spl_send: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    $rose(i_phy[1].link_up) |=> spl_r[1]) else $error("slot power message missing");
  a_l1_grant: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    s_l1_grant |=> l1ent_r && !l0s_r[UP_PORT]) else $error("granted sleep not entered");
  a_l1_dn_ready: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    l1_fire |-> $past(l1_en_r[UP_PORT]) && $past(dn_l1_ok)) else $error("sleep asked with active downstream");
endmodule : spl_link_ctrl

// File: bench/spl_partner.sv
// Link partner model for one port: training walk, link level, power message.
// Assumes the switch clock; training starts on a bench request or a retrain.
`timescale 1ns/1ps
module spl_partner (
  // Clock, reset and bench controls
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  input wire logic i_up,
  input wire logic [5:0] i_w,
  input wire logic [7:0] i_inv,
  input wire logic [15:0] i_pay,
  input wire logic i_spl,
  // Switch side
  input wire spl_pkg::spl_phy_out_t i_cmd,
  output spl_pkg::spl_phy_in_t o_phy
);
  import spl_pkg::*;
  logic [4:0] k_r; // Training step, 0 when idle
  // Step counter; a retrain restarts training as Recovery would
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      k_r <= 5'h00;
    else if (i_go || i_cmd.retrain)
      k_r <= 5'h01;
    else
      k_r <= (k_r == 5'h00 || k_r == 5'h13) ? 5'h00 : k_r + 5'h01;
  end
  // Off-window symbols carry the opposite pattern, so a loose window shows up
  always_comb
  begin
    o_phy = '0;
    o_phy.train_start = (k_r == 5'h01);
    o_phy.train = (k_r != 5'h00) && (k_r < 5'h13);
    o_phy.sym_idx = k_r - 5'h01;
    o_phy.sym_inv = (k_r >= 5'h07 && k_r <= 5'h11) ? i_inv : ~i_inv;
    o_phy.train_done = (k_r == 5'h13);
    o_phy.neg_width = i_w;
    o_phy.link_up = i_up;
    o_phy.tlp_idle = 1'b1;
    o_phy.spl_valid = i_spl;
    o_phy.spl_payload = i_pay;
  end
endmodule : spl_partner

// File: bench/test_switch_port_link_control.sv
// Self-checking bench of the link control block with one partner per port.
// Assumes APB register access and a single 40 ns clock.
`timescale 1ns/1ps
module test_switch_port_link_control;
  import spl_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, spl = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, err;
  logic [15:0] seed = 16'ha3b3, pay = 16'h0000;
  logic [2:0] go = 3'h0, up = 3'h0;
  logic [2:0][5:0] w = '0;
  logic [2:0][7:0] inv = '0;
  spl_phy_in_t [NPORT-1:0] phy_in;
  spl_phy_out_t [NPORT-1:0] phy_out;
  int fails = 0, checked = 0, cyc = 0, nl0 = 0, nret[3], nfl[3], nfc[3], nsp[3];
  // Clock
  always #20 i_clk = ~i_clk;
  spl_link_ctrl uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_phy(phy_in), .o_phy(phy_out));
  for (genvar p = 0; p < NPORT; p++)
  begin : g_far
    spl_partner far (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(go[p]), .i_up(up[p]), .i_w(w[p]),
      .i_inv(inv[p]), .i_pay(pay), .i_spl(spl), .i_cmd(phy_out[p]), .o_phy(phy_in[p]));
  end
  // Pulse counters; credits count only when the advertised amount is right
  always @(posedge i_clk)
  begin
    cyc++;
    for (int p = 0; p < NPORT; p++)
    begin
      if (phy_out[p].retrain === 1'b1) nret[p]++;
      if (phy_out[p].flush === 1'b1) nfl[p]++;
      if (phy_out[p].fc_adv === 1'b1 && phy_out[p].fc_credits === 8'h20) nfc[p]++;
      if (phy_out[p].spl_send === 1'b1) nsp[p]++;
    end
    if (phy_out[0].l0s_enter === 1'b1) nl0++;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Upper group off below x8, unused lower lanes low-power
  function automatic logic [31:0] exp_lanes(input logic [5:0] wd);
    logic [7:0] m;
    m = (8'h01 << wd) - 8'h01;
    return {16'h0, (wd == 6'h08) ? 8'h00 : 8'hf0, ~m & 8'h0f};
  endfunction : exp_lanes
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Partner training with a random inversion pattern
  task automatic train(input int p, input logic [5:0] wd);
    @(posedge i_clk);
    seed = lfsr(seed);
    w[p] <= wd;
    inv[p] <= seed[7:0];
    go[p] <= 1'b1;
    @(posedge i_clk);
    go[p] <= 1'b0;
    repeat (24) @(posedge i_clk);
  endtask : train
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    apb(1'b0, 8'h64, 32'h0);
    chk(rd, 32'h1f07);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h24, 32'h4);
    apb(1'b1, 8'h00, 32'h1);
    repeat (3) @(posedge i_clk);
    chk(nret[0], 0);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, 8'h60, 32'h1);
    apb(1'b1, 8'h24, 32'h4);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h4);
    chk({26'h0, phy_out[1].max_width}, 32'h8);
    apb(1'b1, 8'h20, 32'h1);
    repeat (3) @(posedge i_clk);
    chk(nret[1], 1);
    chk({26'h0, phy_out[1].max_width}, 32'h4);
    apb(1'b1, 8'h00, 32'h1);
    repeat (3) @(posedge i_clk);
    chk(nret[0], 1);
    up[1] <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(nfc[1], 1);
    chk(nsp[1], 1);
    chk({31'h0, phy_out[1].dest_ur}, 32'h0);
    apb(1'b1, 8'h30, {seed, seed});
    repeat (3) @(posedge i_clk);
    chk(nsp[1], 2);
    up[1] <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(nfl[1], 1);
    chk({31'h0, phy_out[1].dest_ur}, 32'h1);
    apb(1'b1, 8'h30, 32'h5);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h5);
    chk(nsp[1], 2);
    seed = lfsr(seed);
    pay <= seed;
    spl <= 1'b1;
    @(posedge i_clk);
    spl <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, {22'h0, seed[9:8], seed[7:0]});
    for (int i = 0; i < 4; i++)
    begin
      train(2, 6'h01 << i);
      apb(1'b0, 8'h48, 32'h0);
      chk(rd, {8'h0, inv[2], 7'h0, up[2], 2'h0, w[2]});
      chk({16'h0, phy_out[2].lane_off, phy_out[2].lane_lp}, exp_lanes(w[2]));
    end
    apb(1'b1, 8'h40, 32'h8);
    repeat (3) @(posedge i_clk);
    chk({24'h0, phy_out[2].lane_off}, 32'hff);
    // Upstream standby after one timer unit; downstreams are down so they do not block it
    apb(1'b1, 8'h64, 32'h1f01);
    up[0] <= 1'b1;
    apb(1'b1, 8'h00, 32'h2);
    repeat (10) @(posedge i_clk);
    chk(nl0, 0);
    repeat (30) @(posedge i_clk);
    chk(nl0, 1);
    tally_and_finish();
  end
endmodule : test_switch_port_link_control
